// >>> logic/wpf_wake_filter.sv
// Wake-up frame filter: fixed and flexible filters, link wake, frame store, PME
//
// Function
// R01 - Tagged resolution wake needs resolution wake enabled
// R02 - Link change wakes, gated by PME enable
// R03 - Resolution frame wakes, gated by PME enable
// R04 - Multicast match wakes, gated by PME enable
// R05 - Station address match wakes, gated by PME enable
// R06 - Low IP byte at 40, or 44 tagged
// R07 - High IP byte at 41, or 45 tagged
// R08 - Pattern disable blocks pattern frame wake
// R09 - Link connect or disconnect raises event
// R10 - Link event recorded in driver register
// R11 - Link events never store a frame
// R12 - Three independent flexible filters
// R13 - Segments: dword bounds plus two byte masks
// R14 - 32-bit signature over masked bytes matches
// R15 - Output 25 MHz clock; outside feeds clock
// R16 - Forced management pin disables flex and storage
// R17 - Only first 124 bytes filtered and stored
// R18 - Host limits segments to ten total
// R19 - Stored frame held for driver
// R20 - Fixed filter frames also stored
// R21 - Lost frames wake without storage
// R22 - Fixed filters need a good CRC
// R23 - PME is OR of enabled sources
`timescale 1ns/1ns
`include "wpf_map.svh"
module wpf_wake_filter #(
  parameter int NSEG = wpf_pkg::NSEG
) (
  input  wire logic            mclk,      // 100 MHz clock
  input  wire logic            resetn,    // Async reset
  input  wire logic [7:0]      addr,      // Register byte address
  input  wire logic [31:0]     wdata,     // Write data
  input  wire logic            wstrobe,   // Write strobe
  input  wire logic            rstrobe,   // Read strobe
  output logic      [31:0]     rdata,     // Read data, next cycle
  input  wire wpf_pkg::wpf_rx_s rx,       // Receive stream
  input  wire logic            link_pin,  // Link status from PHY
  input  wire logic            forced_management_pin, // Forced mode pin
  input  wire logic            pme_en,    // PM enable from PCI logic
  output logic                 pme_n,     // Wake event, active low
  output logic                 clk_25     // 25 MHz clock out
);
  wpf_pkg::wpf_state_s s_q;
  wpf_pkg::wpf_state_s s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `WPF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic incl(input wpf_pkg::wpf_seg_s sg,
                                input logic [6:0] b);
    logic [4:0] dw;
    dw = b[6:2];
    incl = sg.vld && dw >= sg.first && dw <= sg.last &&
           (dw != sg.first || sg.fmask[b[1:0]]) &&
           (dw != sg.last || sg.lmask[b[1:0]]);
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int n);
    in_range = a >= base && a < base + 8'(4 * n) && a[1:0] == 2'b00;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic [2:0]  flex_hit;
  logic [2:0]  flex_loaded;
  logic [8:0]  st_set;
  logic [8:0]  st_clr;
  logic        link_chg;
  logic        forced;
  logic        frame_ev;
  logic        store_ok;
  logic        hold;
  logic        arp_nv;
  logic        arp_v;
  logic        take;
  logic [6:0]  b;
  logic [7:0]  ofs;
  logic [3:0]  si;
  logic [4:0]  wi;

  always_comb begin
    s_d      = s_q;
    st_set   = '0;
    st_clr   = '0;
    b        = s_q.bcnt;
    ofs      = '0;
    si       = '0;
    wi       = '0;
    take     = 1'b0;
    flex_hit = '0;
    flex_loaded = '0;
    forced   = s_q.frc2;
    hold     = s_q.sts[`WPF_ST_STORED];

    // Output clock divider
    s_d.div = s_q.div + 2'd1;
    if (s_q.div == 2'(`WPF_DIV_HALF - 1)) begin  // see R15
      s_d.div   = '0;
      s_d.clk25 = ~s_q.clk25;
    end

    // Pin synchronisers
    s_d.lnk1 = link_pin;
    s_d.lnk2 = s_q.lnk1;
    s_d.lnk3 = s_q.lnk2;
    s_d.frc1 = forced_management_pin;
    s_d.frc2 = s_q.frc1;
    link_chg = s_q.lnk2 ^ s_q.lnk3;  // see R09

    // Byte intake; bytes past the window are dropped
    if (rx.valid && s_q.bcnt < `WPF_MAX_BYTES) begin  // see R17
      s_d.bcnt = s_q.bcnt + 7'd1;
      for (int f = 0; f < wpf_pkg::NFLT; f++) begin  // see R12
        take = 1'b0;
        for (int j = 0; j < NSEG; j++) begin
          if (s_q.seg[j].filter == 2'(f) && incl(s_q.seg[j], b)) begin
            take = 1'b1;  // see R13
          end
        end
        if (take) begin
          s_d.crc[f] = crc8(s_q.crc[f], rx.data);  // see R14
        end
      end
      // Buffer frozen while a stored frame awaits the driver
      if (!hold && !forced) begin  // see R19
        s_d.buffer[b[6:2]][8*b[1:0] +: 8] = rx.data;
      end
      if (b == `WPF_B_TYPE_HI && rx.data == `WPF_ARP_TYPE_HI) begin
        s_d.arp[0] = 1'b1;
      end
      if (b == `WPF_B_TYPE_LO && rx.data == `WPF_ARP_TYPE_LO) begin
        s_d.arp[1] = 1'b1;
      end
      if (b == `WPF_B_OPCODE && rx.data == `WPF_ARP_REQ) begin
        s_d.arp[2] = 1'b1;
      end
      if (b == `WPF_B_IP_LO && rx.data == s_q.ip[7:0]) begin
        s_d.arp[3] = 1'b1;  // see R06
      end
      if (b == `WPF_B_IP_HI && rx.data == s_q.ip[15:8]) begin
        s_d.arp[4] = 1'b1;  // see R07
      end
      if (b == `WPF_B_TYPE_HI + `WPF_VLAN_SHIFT &&
          rx.data == `WPF_ARP_TYPE_HI) begin
        s_d.arp[5] = 1'b1;
      end
      if (b == `WPF_B_TYPE_LO + `WPF_VLAN_SHIFT &&
          rx.data == `WPF_ARP_TYPE_LO) begin
        s_d.arp[6] = 1'b1;
      end
      if (b == `WPF_B_OPCODE + `WPF_VLAN_SHIFT &&
          rx.data == `WPF_ARP_REQ) begin
        s_d.arp[7] = 1'b1;
      end
      if (b == `WPF_B_IP_LO + `WPF_VLAN_SHIFT &&
          rx.data == s_q.ip[7:0]) begin
        s_d.arp[8] = 1'b1;  // see R06
      end
      if (b == `WPF_B_IP_HI + `WPF_VLAN_SHIFT &&
          rx.data == s_q.ip[15:8]) begin
        s_d.arp[9] = 1'b1;  // see R07
      end
    end

    // Frame end: evaluate filters
    arp_nv = &s_q.arp[4:0];
    arp_v  = s_q.cfg[`WPF_CFG_TAGGED] && &s_q.arp[9:5];  // see R01
    for (int f = 0; f < wpf_pkg::NFLT; f++) begin
      for (int j = 0; j < NSEG; j++) begin
        if (s_q.seg[j].vld && s_q.seg[j].filter == 2'(f)) begin
          flex_loaded[f] = 1'b1;
        end
      end
      // Flex path off while forced mode is active
      flex_hit[f] = flex_loaded[f] && s_q.cfg[`WPF_CFG_FLEX] &&
                    !forced && ~s_q.crc[f] == s_q.sig[f];  // see R16
    end
    if (rx.eop) begin
      if (rx.crc_ok) begin  // see R22
        st_set[`WPF_ST_IA]  = s_q.cfg[`WPF_CFG_STATION] && rx.ia_hit;  // see R05
        st_set[`WPF_ST_MC]  = s_q.cfg[`WPF_CFG_MCAST] && rx.mc_hit;  // see R04
        st_set[`WPF_ST_ARP] = s_q.cfg[`WPF_CFG_ARP] && (arp_nv || arp_v);  // see R03
        st_set[`WPF_ST_PAT] = !s_q.cfg[`WPF_CFG_PATDIS] && rx.pat_hit;  // see R08
        st_set[`WPF_ST_FLEX +: 3] = flex_hit;  // see R14
      end
      s_d.bcnt = '0;
      s_d.arp  = '0;
      for (int f = 0; f < wpf_pkg::NFLT; f++) begin
        s_d.crc[f] = `WPF_CRC_INIT;
      end
    end
    // Fixed and flex matches both qualify; lost frames only wake
    frame_ev = |st_set[7:0];  // see R20
    store_ok = frame_ev && s_q.cfg[`WPF_CFG_STORE] && !forced &&
               !rx.overrun && !hold;  // see R21
    if (store_ok) begin
      st_set[`WPF_ST_STORED] = 1'b1;  // see R19
      s_d.len = s_q.bcnt;
    end
    // Link events bypass the store path entirely
    st_set[`WPF_ST_LINK] = s_q.cfg[`WPF_CFG_LINK] && link_chg;  // see R02 R10 R11

    // Register writes
    if (wstrobe) begin
      if (addr == `WPF_OFS_CFG) begin
        s_d.cfg = wdata[7:0];
      end
      if (addr == `WPF_OFS_IPADDR) begin
        s_d.ip = wdata[15:0];
      end
      if (addr == `WPF_OFS_POWER_MGMT_DRIVER_REG) begin
        st_clr = wdata[8:0];
      end
      if (in_range(addr, `WPF_OFS_SIG0, wpf_pkg::NFLT)) begin
        ofs = addr - `WPF_OFS_SIG0;
        s_d.sig[ofs[3:2]] = wdata;
      end
      if (in_range(addr, `WPF_OFS_SEG0, NSEG)) begin
        ofs = addr - `WPF_OFS_SEG0;
        si  = ofs[5:2];
        s_d.seg[si] = wdata[20:0];
      end
    end
    // Hardware set wins over software clear
    s_d.sts = (s_q.sts & ~st_clr) | st_set;

    s_d.pme = pme_en && |s_q.sts[7:0];  // see R23

    // Register reads
    s_d.rdata = '0;
    if (rstrobe) begin
      if (addr == `WPF_OFS_CFG) begin
        s_d.rdata = {24'h00_0000, s_q.cfg};
      end
      if (addr == `WPF_OFS_IPADDR) begin
        s_d.rdata = {16'h0000, s_q.ip};
      end
      if (addr == `WPF_OFS_POWER_MGMT_DRIVER_REG) begin
        s_d.rdata[8:0] = s_q.sts;
        s_d.rdata[`WPF_ST_LEN +: 7] = s_q.len;
        s_d.rdata[`WPF_ST_LIVE] = s_q.lnk2;
      end
      if (in_range(addr, `WPF_OFS_SIG0, wpf_pkg::NFLT)) begin
        ofs = addr - `WPF_OFS_SIG0;
        s_d.rdata = s_q.sig[ofs[3:2]];
      end
      if (in_range(addr, `WPF_OFS_SEG0, NSEG)) begin
        ofs = addr - `WPF_OFS_SEG0;
        si  = ofs[5:2];
        s_d.rdata = {11'h000, s_q.seg[si]};
      end
      if (in_range(addr, `WPF_OFS_BUF0, wpf_pkg::NWORD)) begin
        ofs = addr - `WPF_OFS_BUF0;
        wi  = ofs[6:2];
        s_d.rdata = s_q.buffer[wi];
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.cfg   <= `WPF_CFG_RST;
      s_q.crc   <= {wpf_pkg::NFLT{`WPF_CRC_INIT}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata  = s_q.rdata;
  assign pme_n  = ~s_q.pme;
  assign clk_25 = s_q.clk25;
endmodule

// >>> logic/wpf_map.svh
// Register offsets, field positions, reset values and timing counts of the wake packet filter
`ifndef WPF_MAP_SVH
`define WPF_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define WPF_OFS_CFG      8'h00
`define WPF_OFS_IPADDR   8'h04
`define WPF_OFS_POWER_MGMT_DRIVER_REG     8'h08
`define WPF_OFS_SIG0     8'h10
`define WPF_OFS_SEG0     8'h40
`define WPF_OFS_BUF0     8'h80
// ****************************************
// Configuration fields
// ****************************************
`define WPF_CFG_STATION  0
`define WPF_CFG_MCAST    1
`define WPF_CFG_ARP      2
`define WPF_CFG_TAGGED   3
`define WPF_CFG_LINK     4
`define WPF_CFG_PATDIS   5
`define WPF_CFG_FLEX     6
`define WPF_CFG_STORE    7
`define WPF_CFG_RST      8'h00
// ****************************************
// Driver register fields
// ****************************************
`define WPF_ST_IA        0
`define WPF_ST_MC        1
`define WPF_ST_ARP       2
`define WPF_ST_PAT       3
`define WPF_ST_LINK      4
`define WPF_ST_FLEX      5
`define WPF_ST_STORED    8
`define WPF_ST_LEN       16
`define WPF_ST_LIVE      24
// ****************************************
// Frame layout and signature
// ****************************************
`define WPF_MAX_BYTES    7'd124
`define WPF_B_TYPE_HI    7'd12
`define WPF_B_TYPE_LO    7'd13
`define WPF_B_OPCODE     7'd21
`define WPF_B_IP_LO      7'd40
`define WPF_B_IP_HI      7'd41
`define WPF_VLAN_SHIFT   7'd4
`define WPF_ARP_TYPE_HI  8'h08
`define WPF_ARP_TYPE_LO  8'h06
`define WPF_ARP_REQ      8'h01
`define WPF_CRC_INIT     32'hFFFF_FFFF
`define WPF_CRC_POLY     32'hEDB8_8320
// ****************************************
// Timing
// ****************************************
`define WPF_CLK_MHZ      100
`define WPF_OUT_MHZ      25
`define WPF_DIV_HALF     (`WPF_CLK_MHZ / `WPF_OUT_MHZ / 2)
`endif

// >>> logic/wpf_pkg.sv
// Types shared by the wake packet filter
package wpf_pkg;
  localparam int NSEG  = 10;
  localparam int NFLT  = 3;
  localparam int NWORD = 31;

  typedef struct packed {
    logic       valid;    // Byte strobe
    logic [7:0] data;     // Frame byte
    logic       eop;      // End of frame, own cycle
    logic       crc_ok;   // Frame CRC good
    logic       overrun;  // Frame lost
    logic       ia_hit;   // Passed station address filter
    logic       mc_hit;   // Passed multicast filter
    logic       pat_hit;  // Remote-wake pattern frame
  } wpf_rx_s;

  typedef struct packed {
    logic       vld;
    logic [1:0] filter;
    logic [3:0] lmask;
    logic [3:0] fmask;
    logic [4:0] last;
    logic [4:0] first;
  } wpf_seg_s;

  typedef struct packed {
    logic [7:0]                 cfg;
    logic [15:0]                ip;
    logic [8:0]                 sts;
    logic [6:0]                 len;
    logic [NFLT-1:0][31:0]      sig;
    wpf_seg_s [NSEG-1:0]        seg;
    logic [NWORD-1:0][31:0]     buffer;
    logic [6:0]                 bcnt;
    logic [NFLT-1:0][31:0]      crc;
    logic [9:0]                 arp;
    logic                       lnk1;
    logic                       lnk2;
    logic                       lnk3;
    logic                       frc1;
    logic                       frc2;
    logic [1:0]                 div;
    logic                       clk25;
    logic                       pme;
    logic [31:0]                rdata;
  } wpf_state_s;
endpackage

// >>> test/wpf_wake_filter_sva.sv
// Concurrent checks on the ports of the wake packet filter
`timescale 1ns/1ns
`include "wpf_map.svh"
module wpf_wake_filter_sva #(
  parameter int NSEG = wpf_pkg::NSEG
) (
  input wire logic        mclk,    // Clock
  input wire logic        resetn,  // Async reset
  input wire logic [7:0]  addr,    // Register address
  input wire logic [31:0] wdata,   // Write data
  input wire logic        wstrobe, // Write strobe
  input wire logic        rstrobe, // Read strobe
  input wire logic [31:0] rdata,   // Read data
  input wire logic        pme_en,  // PM enable
  input wire logic        pme_n,   // Wake output
  input wire logic        clk_25   // Clock out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ************
  // Register port
  // ************
  sequence s_wr_rd(logic [7:0] a);
    wstrobe && addr == a ##1 rstrobe && addr == a;
  endsequence
  property p_rd_idle;
    !$past(rstrobe) |-> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    rstrobe && addr == 8'h0c |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_rw;
    s_wr_rd(`WPF_OFS_CFG) |=> rdata == {24'h00_0000, $past(wdata[7:0], 2)};
  endproperty
  a_cfg_rw: assert property (p_cfg_rw) else $error("config readback wrong");
  property p_ip_rw;
    s_wr_rd(`WPF_OFS_IPADDR) |=> rdata == {16'h0000, $past(wdata[15:0], 2)};
  endproperty
  a_ip_rw: assert property (p_ip_rw) else $error("address readback wrong");
  // ************
  // Wake output and clock
  // ************
  property p_clk25;
    $changed(clk_25) |=> $stable(clk_25) ##1 $changed(clk_25);
  endproperty
  a_clk25: assert property (p_clk25) else $error("clock out not quarter rate");
  property p_pme_off;
    !pme_en && !$past(pme_en) |-> pme_n;
  endproperty
  a_pme_off: assert property (p_pme_off) else $error("wake without enable");
  property p_pme_hold;
    !pme_n && pme_en && $past(pme_en) && !wstrobe && !$past(wstrobe) |=> !pme_n;
  endproperty
  a_pme_hold: assert property (p_pme_hold) else $error("wake dropped early");
  property p_pme_fall;
    $fell(pme_n) |-> $past(pme_en);
  endproperty
  a_pme_fall: assert property (p_pme_fall) else $error("wake rose while gated");
endmodule
bind wpf_wake_filter wpf_wake_filter_sva #(.NSEG(NSEG)) u_wpf_wake_filter_sva (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
  .rstrobe(rstrobe), .rdata(rdata), .pme_en(pme_en), .pme_n(pme_n), .clk_25(clk_25));

// >>> test/wpf_phy_model.sv
// Link-side frame source standing in for the physical layer device
`timescale 1ns/1ns
module wpf_phy_model (
  input  wire logic         mclk,     // Clock
  output wpf_pkg::wpf_rx_s  rx,       // Receive stream
  output logic              link_pin  // Link level
);
  initial begin
    rx       = '0;
    link_pin = 1'b0;
  end
  // Flags {crc_ok, overrun, ia, mc, pat} only mean something in the eop cycle
  task automatic send(input logic [7:0] b [130], input int n, input logic [4:0] f);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx.valid <= 1'b1;
      rx.data  <= b[i];
    end
    @(posedge mclk);
    rx.valid <= 1'b0;
    rx.data  <= ~b[n-1];
    rx.eop   <= 1'b1;
    {rx.crc_ok, rx.overrun, rx.ia_hit, rx.mc_hit, rx.pat_hit} <= f;
    @(posedge mclk);
    rx.eop   <= 1'b0;
    {rx.crc_ok, rx.overrun, rx.ia_hit, rx.mc_hit, rx.pat_hit} <= ~f;
  endtask
  task automatic set_link(input logic v);
    @(posedge mclk);
    link_pin <= v;
  endtask
endmodule

// >>> test/testbench.sv
// Directed testbench of the wake packet filter
`timescale 1ns/1ns
`include "wpf_map.svh"
module testbench;
  logic             mclk, resetn, wstrobe, rstrobe, pme_en, pme_n, clk_25, link_pin;
  logic             forced_management_pin;
  logic [7:0]       addr;
  logic [31:0]      wdata, rdata;
  wpf_pkg::wpf_rx_s rx;
  logic [7:0]       fr [130];
  int               fail_count = 0;
  int               cmp_count = 0;
  logic [31:0]      n_tog, crc_ref;
  logic             c_prev;
  logic [7:0]       tc [6] = '{8'h01, 8'h02, 8'h00, 8'h20, 8'h00, 8'h01};
  logic [4:0]       tf [6] = '{5'h14, 5'h12, 5'h11, 5'h11, 5'h14, 5'h04};
  logic [8:0]       te [6] = '{9'h001, 9'h002, 9'h008, 9'h000, 9'h000, 9'h000};
  wpf_wake_filter u_wpf_wake_filter (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata), .rx(rx), .link_pin(link_pin),
    .forced_management_pin(forced_management_pin), .pme_en(pme_en), .pme_n(pme_n), .clk_25(clk_25));
  wpf_phy_model u_wpf_phy_model (.mclk(mclk), .rx(rx), .link_pin(link_pin));
  // ************
  // Access tasks
  // ************
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bit-serial reference of the flex signature, init all ones
  function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 8; k++) r = (r >> 1) ^ ((r[0] ^ d[k]) ? `WPF_CRC_POLY : 32'h0000_0000);
    return r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wstrobe <= 1'b1;
    addr    <= a;
    wdata   <= d;
    @(posedge mclk);
    wstrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk);
    rstrobe <= 1'b1;
    addr    <= a;
    @(posedge mclk);
    rstrobe <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  // Back-to-back write and read, no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rstrobe <= 1'b1;
    @(posedge mclk);
    rstrobe <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Send one frame under config c, check event bits, then clear them
  task automatic run(input logic [7:0] c, input logic [4:0] f, input int n, input logic [8:0] e);
    wr(`WPF_OFS_CFG, {24'h00_0000, c});
    u_wpf_phy_model.send(fr, n, f);
    repeat (3) @(posedge mclk);
    #1;
    chk({31'h0, pme_n}, {31'h0, ~|e[7:0]});
    rd(`WPF_OFS_POWER_MGMT_DRIVER_REG, {23'h0, e}, 32'h0000_01ff);
    wr(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0000_01ff);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  // ************
  // Scenarios
  // ************
  initial begin
    {resetn, wstrobe, rstrobe, forced_management_pin, addr, wdata} = '0;
    pme_en = 1'b1;
    for (int i = 0; i < 130; i++) fr[i] = 8'h00;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(`WPF_OFS_CFG, 32'h0000_0000, 32'hffff_ffff);
    rd(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0000_0000, 32'hffff_ffff);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000_0000, 32'hffff_ffff);
    // Four changes in eight cycles whatever the phase
    c_prev = clk_25;
    n_tog  = '0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      n_tog  = n_tog + {31'h0, clk_25 ^ c_prev};
      c_prev = clk_25;
    end
    chk(n_tog, 32'h0000_0004);
    wr_rd(`WPF_OFS_CFG, 32'h0000_00ff, 32'h0000_00ff);
    wr_rd(`WPF_OFS_IPADDR, 32'h0000_3f3d, 32'h0000_3f3d);
    fr[12] = 8'h08; fr[13] = 8'h06; fr[21] = 8'h01; fr[40] = 8'h3d; fr[41] = 8'h3f;
    fr[123] = 8'h5a; fr[124] = 8'ha5;
    run(8'h84, 5'h10, 130, 9'h104);
    rd(8'ha8, 32'h0000_3f3d, 32'h0000_ffff);
    rd(8'hf8, 32'h5a00_0000, 32'hffff_ffff);
    rd(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h007c_0000, 32'h007f_0000);
    run(8'h84, 5'h00, 64, 9'h000);
    run(8'h84, 5'h18, 64, 9'h004);
    forced_management_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    run(8'hc4, 5'h10, 64, 9'h004);
    forced_management_pin <= 1'b0;
    fr[41] = 8'h00;
    run(8'h84, 5'h10, 64, 9'h000);
    fr[41] = 8'h3f;
    fr[40] = 8'h00;
    run(8'h84, 5'h10, 64, 9'h000);
    fr[12] = 8'h81; fr[13] = 8'h00; fr[16] = 8'h08; fr[17] = 8'h06; fr[21] = 8'h00;
    fr[25] = 8'h01; fr[41] = 8'h00; fr[44] = 8'h3d; fr[45] = 8'h3f;
    run(8'h84, 5'h10, 64, 9'h000);
    run(8'h08, 5'h10, 64, 9'h000);
    run(8'h8c, 5'h10, 64, 9'h104);
    rd(8'hac, 32'h0000_3f3d, 32'h0000_ffff);
    for (int i = 0; i < 6; i++) run(tc[i], tf[i], 64, te[i]);
    // Flex: bytes 12,13 of dword 3, all of dword 4, byte 21 of dword 5
    crc_ref = `WPF_CRC_INIT;
    for (int i = 12; i < 22; i++) begin
      if (i < 14 || (i > 15 && i < 20) || i == 21) crc_ref = ref_crc(crc_ref, fr[i]);
    end
    wr(`WPF_OFS_SIG0, ~crc_ref);
    wr(`WPF_OFS_SIG0 + 8'h08, crc_ref);
    wr(`WPF_OFS_SEG0, {11'h000, 1'h1, 2'h0, 4'h2, 4'h3, 5'h05, 5'h03});
    wr(`WPF_OFS_SEG0 + 8'h04, {11'h000, 1'h1, 2'h2, 4'h2, 4'h3, 5'h05, 5'h03});
    rd(`WPF_OFS_SEG0 + 8'h04, 32'h0018_8ca3, 32'hffff_ffff);
    run(8'hc0, 5'h10, 64, 9'h120);
    // Second frame must not overwrite the held one
    u_wpf_phy_model.send(fr, 64, 5'h10);
    fr[44] = 8'h12;
    u_wpf_phy_model.send(fr, 64, 5'h10);
    rd(8'hac, 32'h0000_3f3d, 32'h0000_ffff);
    wr(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0000_01ff);
    forced_management_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    run(8'hc0, 5'h10, 64, 9'h000);
    forced_management_pin <= 1'b0;
    fr[14] = 8'h55;
    fr[30] = 8'h77;
    run(8'h40, 5'h10, 64, 9'h020);
    fr[13] = 8'h11;
    run(8'h40, 5'h10, 64, 9'h000);
    wr(`WPF_OFS_CFG, 32'h0000_0090);
    pme_en <= 1'b0;
    u_wpf_phy_model.set_link(1'b1);
    repeat (6) @(posedge mclk);
    #1;
    chk({31'h0, pme_n}, 32'h0000_0001);
    rd(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0100_0010, 32'h0100_01ff);
    @(posedge mclk);
    pme_en <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, pme_n}, 32'h0000_0000);
    wr(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0000_01ff);
    u_wpf_phy_model.set_link(1'b0);
    repeat (6) @(posedge mclk);
    rd(`WPF_OFS_POWER_MGMT_DRIVER_REG, 32'h0000_0010, 32'h0100_01ff);
    tally_and_finish();
  end
endmodule
